// ===== design/pse_pll_setup_engine.sv
// Purpose: searches and applies pll/divider settings for a wanted clock
// Assumes: requester follows the setup preconditions and masks irqs
// Notes:   search walks multiplier then divider, one pair per cycle
//
// Functional notes
// - four request inputs, code and frequency out
// - modes exact, at-most, at-least, nearest; else illegal
// - codes success, bad freq, bad mode, none, lock
// - pll output never above 50 MHz
// - input frequency outside 10000..25000 kHz rejected
// - wanted clock outside 1..50000 kHz rejected
// - bypass pll when plain division suffices
// - write dividers, select pll output
// - exact frequency always tried first
// - exact mode succeeds only on exact match
// - at-most never exceeds wanted clock
// - at-least never below wanted clock
// - nearest picks closest either side
// - no setup: settings kept, input reported
// - zero poll limit polls forever
// - limit reached: lock fail, settings restored
// - report clock actually in effect
// - lock expected within 100 us
`timescale 1ns/1ps
`default_nettype none
module pse_pll_setup_engine
  import pse_pkg::*;
(
  input  wire logic               clock_in,            // 10 MHz clock
  input  wire logic               resetn_in,           // async reset, low
  input  wire logic               ce_in,               // clock enable
  input  wire logic               start_in,            // request pulse
  input  wire logic [FREQ_W-1:0]  input_frequency_khz_in, // pll input
  input  wire logic [FREQ_W-1:0]  wanted_clock_khz_in, // wanted clock
  input  wire logic [2:0]         match_mode_in,       // match mode
  input  wire logic [LIMIT_W-1:0] lock_poll_limit_in,  // poll limit
  input  wire logic               pll_lock_in,         // pll lock pin
  output logic                    busy_out,            // request running
  output logic                    done_out,            // answer pulse
  output logic [2:0]              result_code_out,     // result code
  output logic [FREQ_W-1:0]       achieved_clock_khz_out, // clock in kHz
  output logic [4:0]              pll_feedback_out,    // multiplier - 1
  output logic [1:0]              pll_post_out,        // post divider code
  output logic                    pll_enable_out,      // pll powered
  output logic [7:0]              system_clock_divider_out, // sys divider
  output logic                    main_sel_pll_out     // main from pll
);
  typedef enum logic [2:0] {
    PSE_IDLE, PSE_CHECK, PSE_SEARCH, PSE_APPLY, PSE_LOCK, PSE_DIV
  } pse_state_t;

  // returns {fits, post code} for a pll output of a kHz
  function automatic logic [2:0] post_pick(input logic [PROD_W-1:0] a);
    logic [2:0] r;
    logic [PROD_W-1:0] cco;
    r = 3'h0;
    for (int p = 3; p >= 0; p--) begin
      cco = PROD_W'(a << (p + 1));
      if (cco >= CCO_MIN_KHZ && cco <= CCO_MAX_KHZ)
        r = {1'b1, 2'(p)};
    end
    return r;
  endfunction

  pse_state_t        state_r, state_nxt;       // control state
  logic [FREQ_W-1:0] fin_r, fin_nxt;           // captured input freq
  logic [FREQ_W-1:0] want_r, want_nxt;         // captured wanted clock
  logic [2:0]        mode_r, mode_nxt;         // captured mode
  logic [LIMIT_W-1:0] lim_r, lim_nxt;          // captured poll limit
  logic [5:0]        m_r, m_nxt;               // candidate multiplier
  logic [7:0]        d_r, d_nxt;               // candidate divider
  logic [5:0]        bm_r, bm_nxt;             // best multiplier
  logic [7:0]        bd_r, bd_nxt;             // best divider
  logic [PROD_W-1:0] berr_r, berr_nxt;         // best error times div
  logic              have_r, have_nxt;         // a best exists
  logic              busy_r, busy_nxt;         // output regs
  logic              done_r, done_nxt;
  logic [2:0]        code_r, code_nxt;
  logic [FREQ_W-1:0] ach_r, ach_nxt;
  logic [4:0]        fb_r, fb_nxt, fbo_r, fbo_nxt;   // live / saved
  logic [1:0]        pd_r, pd_nxt, pdo_r, pdo_nxt;
  logic              pon_r, pon_nxt, pono_r, pono_nxt;
  logic [7:0]        sdiv_r, sdiv_nxt;
  logic              sel_r, sel_nxt;
  logic              lk_meta_r, lk_sync_r;     // lock synchroniser
  logic              poll_go, div_go;          // sub-block starts
  logic              poll_ok, poll_fail, div_done;
  logic [PROD_W-1:0] quo;                      // divider result
  logic [PROD_W-1:0] a_c, wd_c, err_c;         // candidate figures
  logic [2:0]        pp_c;                     // candidate post pick
  logic              side_ok, better;          // candidate verdicts

  // candidate arithmetic: pll out a, want scaled by divider
  always_comb begin
    a_c   = PROD_W'(fin_r * m_r);
    wd_c  = PROD_W'(want_r * d_r);
    err_c = (a_c > wd_c) ? a_c - wd_c : wd_c - a_c;
    pp_c  = post_pick(a_c);
    case (mode_r) // allowed side of the wanted clock
      MATCH_EXACT:    side_ok = (err_c == '0);
      MATCH_AT_MOST:  side_ok = (a_c <= wd_c);
      MATCH_AT_LEAST: side_ok = (a_c >= wd_c);
      default:        side_ok = 1'b1;
    endcase
    // err/d < berr/bd by cross products; strict so bypass wins ties
    better = side_ok && (m_r == 6'h01 || pp_c[2]) &&
             (!have_r || 32'(err_c) * 32'(bd_r) < 32'(berr_r) * 32'(d_r));
  end

  // main sequence
  always_comb begin
    state_nxt = state_r;
    fin_nxt = fin_r; want_nxt = want_r; mode_nxt = mode_r; lim_nxt = lim_r;
    m_nxt = m_r; d_nxt = d_r; bm_nxt = bm_r; bd_nxt = bd_r;
    berr_nxt = berr_r; have_nxt = have_r;
    busy_nxt = busy_r; done_nxt = 1'b0;
    code_nxt = code_r; ach_nxt = ach_r;
    fb_nxt = fb_r; pd_nxt = pd_r; pon_nxt = pon_r;
    fbo_nxt = fbo_r; pdo_nxt = pdo_r; pono_nxt = pono_r;
    sdiv_nxt = sdiv_r; sel_nxt = sel_r;
    poll_go = 1'b0;
    div_go  = 1'b0;
    case (state_r)
      PSE_IDLE: begin
        if (start_in) begin // capture all inputs
          fin_nxt   = input_frequency_khz_in;
          want_nxt  = wanted_clock_khz_in;
          mode_nxt  = match_mode_in;
          lim_nxt   = lock_poll_limit_in;
          busy_nxt  = 1'b1;
          state_nxt = PSE_CHECK;
        end
      end
      PSE_CHECK: begin
        // failures report the input frequency, settings untouched
        ach_nxt = fin_r;
        if (PROD_W'(fin_r) < FIN_MIN_KHZ || PROD_W'(fin_r) > FIN_MAX_KHZ ||
            PROD_W'(want_r) < WANT_MIN_KHZ ||
            PROD_W'(want_r) > WANT_MAX_KHZ ||
            PROD_W'(want_r * SYSDIV_MAX) < PROD_W'(fin_r)) begin
          code_nxt  = RESULT_BAD_FREQUENCY;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = PSE_IDLE;
        end else if (mode_r > MATCH_NEAREST) begin
          code_nxt  = RESULT_BAD_MODE;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = PSE_IDLE;
        end else begin
          m_nxt     = 6'h01; // bypass candidates come first
          d_nxt     = 8'h01;
          have_nxt  = 1'b0;
          state_nxt = PSE_SEARCH;
        end
      end
      PSE_SEARCH: begin
        if (a_c > PLL_OUT_MAX_KHZ || m_r > FB_MULT_MAX) begin
          if (have_r) begin
            state_nxt = PSE_APPLY;
          end else begin // nothing fits
            code_nxt  = RESULT_NO_SETUP;
            done_nxt  = 1'b1;
            busy_nxt  = 1'b0;
            state_nxt = PSE_IDLE;
          end
        end else begin
          if (better) begin
            bm_nxt   = m_r;
            bd_nxt   = d_r;
            berr_nxt = err_c;
            have_nxt = 1'b1;
          end
          if (better && err_c == '0) begin
            state_nxt = PSE_APPLY; // exact hit ends search
          end else if (d_r == SYSDIV_MAX) begin
            d_nxt = 8'h01;
            m_nxt = m_r + 6'h01;
          end else begin
            d_nxt = d_r + 8'h01;
          end
        end
      end
      PSE_APPLY: begin
        m_nxt = bm_r; // recompute figures for the chosen pair
        d_nxt = bd_r;
        if (m_r == bm_r && d_r == bd_r) begin
          if (bm_r == 6'h01) begin // plain division, pll off
            sdiv_nxt  = bd_r;
            sel_nxt   = 1'b0;
            pon_nxt   = 1'b0;
            div_go    = 1'b1;
            state_nxt = PSE_DIV;
          end else begin // program pll, keep old set for undo
            fbo_nxt   = fb_r;
            pdo_nxt   = pd_r;
            pono_nxt  = pon_r;
            fb_nxt    = 5'(bm_r - 6'h01);
            pd_nxt    = pp_c[1:0];
            pon_nxt   = 1'b1;
            poll_go   = 1'b1;
            state_nxt = PSE_LOCK;
          end
        end
      end
      PSE_LOCK: begin
        if (poll_ok) begin // switch main clock once locked
          sdiv_nxt  = bd_r;
          sel_nxt   = 1'b1;
          div_go    = 1'b1;
          state_nxt = PSE_DIV;
        end else if (poll_fail) begin // undo pll writes
          fb_nxt    = fbo_r;
          pd_nxt    = pdo_r;
          pon_nxt   = pono_r;
          code_nxt  = RESULT_LOCK_FAIL;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = PSE_IDLE;
        end
      end
      PSE_DIV: begin
        if (div_done) begin // frequency now in effect
          ach_nxt   = FREQ_W'(quo);
          code_nxt  = RESULT_SUCCESS;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = PSE_IDLE;
        end
      end
      default: state_nxt = PSE_IDLE;
    endcase
  end

  // registers of the main sequence; sys divider resets to 1
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= PSE_IDLE;
      fin_r <= '0; want_r <= '0; mode_r <= 3'h0; lim_r <= '0;
      m_r <= 6'h01; d_r <= 8'h01; bm_r <= 6'h01; bd_r <= 8'h01;
      berr_r <= '0; have_r <= 1'b0;
      busy_r <= 1'b0; done_r <= 1'b0; code_r <= 3'h0; ach_r <= '0;
      fb_r <= 5'h00; pd_r <= 2'h0; pon_r <= 1'b0;
      fbo_r <= 5'h00; pdo_r <= 2'h0; pono_r <= 1'b0;
      sdiv_r <= 8'h01; sel_r <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      fin_r <= fin_nxt; want_r <= want_nxt; mode_r <= mode_nxt;
      lim_r <= lim_nxt;
      m_r <= m_nxt; d_r <= d_nxt; bm_r <= bm_nxt; bd_r <= bd_nxt;
      berr_r <= berr_nxt; have_r <= have_nxt;
      busy_r <= busy_nxt; done_r <= done_nxt; code_r <= code_nxt;
      ach_r <= ach_nxt;
      fb_r <= fb_nxt; pd_r <= pd_nxt; pon_r <= pon_nxt;
      fbo_r <= fbo_nxt; pdo_r <= pdo_nxt; pono_r <= pono_nxt;
      sdiv_r <= sdiv_nxt; sel_r <= sel_nxt;
    end
  end

  // lock comes from the pll's own domain: two flops first
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_meta_r <= 1'b0;
      lk_sync_r <= 1'b0;
    end else if (ce_in) begin
      lk_meta_r <= pll_lock_in;
      lk_sync_r <= lk_meta_r;
    end
  end

  pse_lock_poll #(.LW(LIMIT_W)) u_poll (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .start_in   (poll_go),
    .limit_in   (lim_r),
    .lock_in    (lk_sync_r),
    .locked_out (poll_ok),
    .failed_out (poll_fail)
  );

  pse_divider #(.NW(PROD_W), .DW(8)) u_div (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .start_in  (div_go),
    .num_in    (PROD_W'(fin_r * bm_r)),
    .den_in    (bd_r),
    .done_out  (div_done),
    .quo_out   (quo)
  );

  assign busy_out                 = busy_r;
  assign done_out                 = done_r;
  assign result_code_out          = code_r;
  assign achieved_clock_khz_out   = ach_r;
  assign pll_feedback_out         = fb_r;
  assign pll_post_out             = pd_r;
  assign pll_enable_out           = pon_r;
  assign system_clock_divider_out = sdiv_r;
  assign main_sel_pll_out         = sel_r;

  // checks on the answer against the captured request
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic ok_c;
  logic [PROD_W-1:0] pll_khz_c;
  assign ok_c = done_r && code_r == RESULT_SUCCESS;
  assign pll_khz_c = sel_r ? PROD_W'(fin_r * (fb_r + 6'h01))
                           : PROD_W'(fin_r);

  property p_done_pulse;
    done_r && ce_in |=> !done_r;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");
  property p_bad_fin;
    done_r && (fin_r < 16'h2710 || fin_r > 16'h61a8)
      |-> code_r == RESULT_BAD_FREQUENCY;
  endproperty
  a_bad_fin: assert property (p_bad_fin)
    else $error("input frequency out of range not rejected");
  property p_bad_want;
    done_r && (want_r == 16'h0000 || want_r > 16'hc350)
      |-> code_r == RESULT_BAD_FREQUENCY;
  endproperty
  a_bad_want: assert property (p_bad_want)
    else $error("wanted clock out of range not rejected");
  property p_bad_mode;
    done_r && code_r != RESULT_BAD_FREQUENCY && mode_r > 3'h3
      |-> code_r == RESULT_BAD_MODE;
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("illegal mode not rejected");
  property p_fail_report;
    done_r && code_r != RESULT_SUCCESS |-> ach_r == fin_r;
  endproperty
  a_fail_report: assert property (p_fail_report)
    else $error("failure did not report the input frequency");
  property p_pll_max;
    ok_c |-> pll_khz_c <= PLL_OUT_MAX_KHZ;
  endproperty
  a_pll_max: assert property (p_pll_max)
    else $error("pll output above ceiling");
  property p_exact;
    ok_c && mode_r == MATCH_EXACT
      |-> pll_khz_c == PROD_W'(want_r * sdiv_r);
  endproperty
  a_exact: assert property (p_exact)
    else $error("exact mode gave an inexact clock");
  property p_at_most;
    ok_c && mode_r == MATCH_AT_MOST
      |-> pll_khz_c <= PROD_W'(want_r * sdiv_r);
  endproperty
  a_at_most: assert property (p_at_most)
    else $error("at-most mode exceeded wanted clock");
  property p_at_least;
    ok_c && mode_r == MATCH_AT_LEAST
      |-> pll_khz_c >= PROD_W'(want_r * sdiv_r);
  endproperty
  a_at_least: assert property (p_at_least)
    else $error("at-least mode fell below wanted clock");
  property p_lock_undo;
    done_r && code_r == RESULT_LOCK_FAIL |-> !sel_r == !$past(sel_r, 2);
  endproperty
  a_lock_undo: assert property (p_lock_undo)
    else $error("lock failure changed the clock selection");

  c_bypass: cover property (ok_c && !sel_r);
  c_pll: cover property (ok_c && sel_r);
  c_lock_fail: cover property (done_r && code_r == RESULT_LOCK_FAIL);
  c_no_setup: cover property (done_r && code_r == RESULT_NO_SETUP);
endmodule // pse_pll_setup_engine
`default_nettype wire

// ===== design/pse_pkg.sv
// Purpose: shared constants for the clock-setup engine
// Assumes: 10 MHz system clock, frequencies carried in kHz
// Notes:   every code, limit and timing count lives here
package pse_pkg;
  // match mode codes (3 bits so that illegal codes can arrive)
  localparam logic [2:0] MATCH_EXACT    = 3'h0;
  localparam logic [2:0] MATCH_AT_MOST  = 3'h1;
  localparam logic [2:0] MATCH_AT_LEAST = 3'h2;
  localparam logic [2:0] MATCH_NEAREST  = 3'h3;
  // result codes
  localparam logic [2:0] RESULT_SUCCESS       = 3'h0;
  localparam logic [2:0] RESULT_BAD_FREQUENCY = 3'h1;
  localparam logic [2:0] RESULT_BAD_MODE      = 3'h2;
  localparam logic [2:0] RESULT_NO_SETUP      = 3'h3;
  localparam logic [2:0] RESULT_LOCK_FAIL     = 3'h4;
  // legal request ranges, kHz
  localparam logic [23:0] FIN_MIN_KHZ  = 24'h002710; // 10000
  localparam logic [23:0] FIN_MAX_KHZ  = 24'h0061a8; // 25000
  localparam logic [23:0] WANT_MIN_KHZ = 24'h000001; // 1
  localparam logic [23:0] WANT_MAX_KHZ = 24'h00c350; // 50000
  // pll output ceiling, kHz
  localparam logic [23:0] PLL_OUT_MAX_KHZ = 24'h00c350; // 50000
  // pll oscillator window, kHz
  localparam logic [23:0] CCO_MIN_KHZ = 24'h026160; // 156000
  localparam logic [23:0] CCO_MAX_KHZ = 24'h04e200; // 320000
  // divider limits
  localparam logic [5:0] FB_MULT_MAX = 6'h20;  // 32
  localparam logic [7:0] SYSDIV_MAX  = 8'hff;  // 255
  // field widths
  localparam int FREQ_W  = 16;
  localparam int PROD_W  = 24;
  localparam int LIMIT_W = 32;
  // expected pll lock time
  localparam int CLK_KHZ          = 10000;
  localparam int LOCK_TIME_US     = 100;
  localparam int LOCK_TIME_CYCLES = LOCK_TIME_US * CLK_KHZ / 1000;
endpackage

// ===== design/pse_divider.sv
// Purpose: serial restoring divider for the achieved clock figure
// Assumes: den is nonzero; one quotient bit per enabled cycle
// Notes:   done pulses one cycle; quo holds until next start
`timescale 1ns/1ps
`default_nettype none
module pse_divider #(
  parameter int NW = 24, // numerator width
  parameter int DW = 8   // denominator width
) (
  input  wire logic          clock_in,  // system clock
  input  wire logic          resetn_in, // async reset, low
  input  wire logic          ce_in,     // clock enable
  input  wire logic          start_in,  // begin a division
  input  wire logic [NW-1:0] num_in,    // dividend
  input  wire logic [DW-1:0] den_in,    // divisor
  output logic               done_out,  // quotient ready pulse
  output logic      [NW-1:0] quo_out    // quotient
);
  logic [NW-1:0] quo_r, quo_nxt;   // shifting dividend/quotient
  logic [DW:0]   rem_r, rem_nxt;   // partial remainder
  logic [DW-1:0] den_r, den_nxt;   // held divisor
  logic [5:0]    cnt_r, cnt_nxt;   // bits left
  logic          done_r, done_nxt; // finish pulse
  logic [DW:0]   trial;            // remainder with next bit

  // one restoring step per cycle
  always_comb begin
    quo_nxt  = quo_r;
    rem_nxt  = rem_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    trial    = {rem_r[DW-1:0], quo_r[NW-1]};
    if (start_in) begin
      quo_nxt = num_in;
      rem_nxt = '0;
      den_nxt = den_in;
      cnt_nxt = 6'(NW);
    end else if (cnt_r != 6'h00) begin
      if (trial >= {1'b0, den_r}) begin // subtract fits
        rem_nxt = trial - {1'b0, den_r};
        quo_nxt = {quo_r[NW-2:0], 1'b1};
      end else begin
        rem_nxt = trial;
        quo_nxt = {quo_r[NW-2:0], 1'b0};
      end
      cnt_nxt  = cnt_r - 6'h01;
      done_nxt = (cnt_r == 6'h01);
    end
  end

  // registers, frozen while ce is low
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      quo_r  <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= 6'h00;
      done_r <= 1'b0;
    end else if (ce_in) begin
      quo_r  <= quo_nxt;
      rem_r  <= rem_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
  assign quo_out  = quo_r;
endmodule // pse_divider
`default_nettype wire

// ===== design/pse_lock_poll.sv
// Purpose: counts lock checks against the requested poll limit
// Assumes: lock_in is already synchronised; one check per cycle
// Notes:   a zero limit never gives up
`timescale 1ns/1ps
`default_nettype none
module pse_lock_poll #(
  parameter int LW = 32 // poll limit width
) (
  input  wire logic          clock_in,   // system clock
  input  wire logic          resetn_in,  // async reset, low
  input  wire logic          ce_in,      // clock enable
  input  wire logic          start_in,   // begin polling
  input  wire logic [LW-1:0] limit_in,   // checks allowed, 0 = no limit
  input  wire logic          lock_in,    // synchronised lock level
  output logic               locked_out, // lock seen pulse
  output logic               failed_out  // limit used up pulse
);
  logic          act_r, act_nxt;       // polling in progress
  logic [LW-1:0] cnt_r, cnt_nxt;       // checks made so far
  logic          locked_r, locked_nxt; // lock pulse
  logic          failed_r, failed_nxt; // fail pulse

  // one check per cycle while active
  always_comb begin
    act_nxt    = act_r;
    cnt_nxt    = cnt_r;
    locked_nxt = 1'b0;
    failed_nxt = 1'b0;
    if (start_in) begin
      act_nxt = 1'b1;
      cnt_nxt = '0;
    end else if (act_r) begin
      if (lock_in) begin // lock wins over a final check
        act_nxt    = 1'b0;
        locked_nxt = 1'b1;
      end else if (limit_in != '0 && cnt_r + LW'(1) == limit_in) begin
        act_nxt    = 1'b0;
        failed_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + LW'(1); // wraps freely when limit is 0
      end
    end
  end

  // registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_r    <= 1'b0;
      cnt_r    <= '0;
      locked_r <= 1'b0;
      failed_r <= 1'b0;
    end else if (ce_in) begin
      act_r    <= act_nxt;
      cnt_r    <= cnt_nxt;
      locked_r <= locked_nxt;
      failed_r <= failed_nxt;
    end
  end

  assign locked_out = locked_r;
  assign failed_out = failed_r;
endmodule // pse_lock_poll
`default_nettype wire

// ===== test/pse_pll_model.sv
// Purpose: pll lock model facing the clock-setup engine
// Assumes: lock follows power-up of the pll after a set delay
// Notes:   hold_in keeps lock low so a lock failure can be forced
`timescale 1ns/1ps
`default_nettype none
module pse_pll_model (
  input  wire logic        clock_in,  // system clock
  input  wire logic        resetn_in, // async reset, low
  input  wire logic        enable_in, // pll powered
  input  wire logic        hold_in,   // never lock
  input  wire logic [15:0] delay_in,  // cycles to lock
  output logic             lock_out   // lock level
);
  logic [15:0] cnt_r; // cycles since power-up
  // count while powered, restart on power-down
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) cnt_r <= 16'h0000;
    else if (!enable_in) cnt_r <= 16'h0000;
    else if (cnt_r != 16'hffff) cnt_r <= cnt_r + 16'h0001;
  end
  // bench keeps the delay below 100 us, i.e. 1000 cycles
  assign lock_out = enable_in && !hold_in && (cnt_r >= delay_in);
endmodule // pse_pll_model
`default_nettype wire

// ===== test/pse_pll_setup_engine_tb.sv
// Purpose: self-checking bench for the clock-setup engine
// Assumes: requests sent one at a time, pll model on the far side
// Notes:   expected figures worked out by hand from the rules
`timescale 1ns/1ps
`default_nettype none
module pse_pll_setup_engine_tb;
  import pse_pkg::*;
  logic clock_in = 0, resetn_in = 0, start_in = 0, pll_lock_in, hold = 0;
  logic ce = 1'b1; // clock enable, dropped once mid-search
  logic [FREQ_W-1:0] fin = 0, want = 0, khz; // request and answer kHz
  logic [2:0] mode = 0, code; // match mode, result code
  logic [LIMIT_W-1:0] lim = 0; // lock-poll limit
  logic [15:0] dly = 16'h0032; // model lock delay
  logic busy, done, en, sel; // engine status and pll outputs
  logic [4:0] fb, fb_old; // feedback setting
  logic [1:0] post, post_old; // post divider setting
  logic [7:0] div; // system divider
  int bad_count = 0, n_tests = 0;
  always #50 clock_in = ~clock_in;
  pse_pll_setup_engine dut (.clock_in, .resetn_in, .ce_in(ce), .start_in,
    .input_frequency_khz_in(fin), .wanted_clock_khz_in(want),
    .match_mode_in(mode), .lock_poll_limit_in(lim), .pll_lock_in,
    .busy_out(busy), .done_out(done), .result_code_out(code),
    .achieved_clock_khz_out(khz), .pll_feedback_out(fb),
    .pll_post_out(post), .pll_enable_out(en),
    .system_clock_divider_out(div), .main_sel_pll_out(sel));
  pse_pll_model pll (.clock_in, .resetn_in, .enable_in(en), .hold_in(hold),
    .delay_in(dly), .lock_out(pll_lock_in));
  // one comparison, counted
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // one request: start pulse, bounded wait for done, check answer
  task req(input int f, input int w, input logic [2:0] m,
           input logic [31:0] l, input logic [2:0] ec, input int ek);
    int i;
    @(posedge clock_in);
    start_in <= 1'b1;
    fin <= f[15:0];
    want <= w[15:0];
    mode <= m;
    lim <= l;
    @(posedge clock_in);
    start_in <= 1'b0;
    @(negedge clock_in);
    chk("busy", 32'h1, {31'h0, busy});
    for (i = 0; i < 4000; i++) begin // no other request runs meanwhile
      @(negedge clock_in);
      if (done === 1'b1) break;
    end
    chk("done", 32'h1, {31'h0, done});
    chk("idle", 32'h0, {31'h0, busy});
    chk("code", {29'h0, ec}, {29'h0, code});
    chk("khz", ek, {16'h0, khz});
    if (ec === RESULT_SUCCESS && en === 1'b1)
      chk("pllmax", 32'h1, {31'h0, (32'(fin) * (32'(fb) + 32'h1))
          <= 32'(PLL_OUT_MAX_KHZ)});
  endtask
  task complete_run;
    $display("tests %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the longest searches
  initial begin
    #3000000; // tests need about 6000 cycles; this allows 30000
    bad_count++;
    complete_run;
  end
  // freeze the engine mid-search; the answer must not change
  initial begin
    repeat (200) @(posedge clock_in);
    ce <= 1'b0;
    repeat (10) @(posedge clock_in);
    ce <= 1'b1;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(negedge clock_in);
    chk("div", 32'h1, {24'h0, div});
    chk("sel", 32'h0, {31'h0, sel});
    req(12000, 6000, MATCH_EXACT, 0, RESULT_SUCCESS, 6000);
    chk("en", 32'h0, {31'h0, en});
    chk("div", 32'h2, {24'h0, div});
    req(9999, 5000, MATCH_EXACT, 0, RESULT_BAD_FREQUENCY, 9999);
    req(25001, 5000, MATCH_EXACT, 0, RESULT_BAD_FREQUENCY, 25001);
    req(12000, 0, MATCH_EXACT, 0, RESULT_BAD_FREQUENCY, 12000);
    req(12000, 50001, MATCH_EXACT, 0, RESULT_BAD_FREQUENCY, 12000);
    req(12000, 40, MATCH_AT_MOST, 0, RESULT_BAD_FREQUENCY, 12000);
    for (int m = 4; m < 8; m++)
      req(12000, 6000, m[2:0], 0, RESULT_BAD_MODE, 12000);
    req(12000, 25000, MATCH_EXACT, 0, RESULT_NO_SETUP, 12000);
    chk("div", 32'h2, {24'h0, div});
    dly <= 16'h0320; // slow lock, still inside 100 us
    req(12000, 24000, MATCH_EXACT, 0, RESULT_SUCCESS, 24000);
    chk("sel", 32'h1, {31'h0, sel});
    chk("fb", 32'h1, {27'h0, fb});
    chk("post", 32'h2, {30'h0, post});
    chk("div", 32'h1, {24'h0, div});
    req(12000, 25000, MATCH_AT_MOST, 2400, RESULT_SUCCESS, 24000);
    req(12000, 25000, MATCH_AT_LEAST, 0, RESULT_SUCCESS, 36000);
    req(12000, 16500, MATCH_NEAREST, 0, RESULT_SUCCESS, 16000);
    fb_old = fb;
    post_old = post;
    hold <= 1'b1;
    req(12000, 36000, MATCH_EXACT, 5, RESULT_LOCK_FAIL, 12000);
    chk("fb", {27'h0, fb_old}, {27'h0, fb});
    chk("post", {30'h0, post_old}, {30'h0, post});
    chk("div", 32'h3, {24'h0, div});
    chk("sel", 32'h1, {31'h0, sel});
    complete_run;
  end
endmodule // pse_pll_setup_engine_tb
`default_nettype wire
